// *** src/nvmsh_top.sv ***
`timescale 1ns/10ps
`include "nvmsh_regs.svh"
module nvmsh_top
    import nvmsh_pkg::*;
#(
    parameter int OWN_LIMIT_CYC = `NVMSH_OWN_MAX_CYC
) (
    // clock, reset, enable
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    // reload events
    input wire logic PCI_RST_DONE,
    input wire logic WAKE_D3_D0,
    input wire logic SW_RESET,
    // configuration space
    input wire logic CFG_WE,
    input wire logic [7:0] CFG_ADDR,
    input wire logic [31:0] CFG_WDATA,
    output logic [31:0] CFG_RDATA,
    // host memory window
    input wire logic MEM_REQ,
    input wire logic MEM_WE,
    input wire logic [31:0] MEM_ADDR,
    input wire logic [31:0] MEM_WDATA,
    output logic MEM_ACK,
    output logic [31:0] MEM_RDATA,
    // firmware shadow port
    input wire logic FW_SR_REQ,
    input wire logic FW_SR_WE,
    input wire nvmsh_sidx_t FW_SR_ADDR,
    input wire logic [15:0] FW_SR_WDATA,
    output logic FW_SR_ACK,
    output logic [15:0] FW_SR_RDATA,
    // commit and protection
    input wire logic FW_COMMIT,
    input wire logic FW_OWNS,
    input wire logic AUTH_OK,
    input wire logic PROTECT_EN,
    input wire logic BLANK_MODE,
    input wire logic [23:0] OPTROM_SIZE,
    output logic COMMIT_BUSY,
    output logic COMMIT_DONE,
    output logic COMMIT_ERR,
    output logic OWN_OVERTIME,
    // status
    output logic LOAD_BUSY,
    output logic VALID_SECTION,
    output logic USING_DEFAULTS,
    // flash word port
    output logic FL_REQ,
    output logic FL_WE,
    output nvmsh_faddr_t FL_ADDR,
    output logic [15:0] FL_WDATA,
    input wire logic FL_ACK,
    input wire logic [15:0] FL_RDATA
);
    localparam int FWB = `NVMSH_FLASH_WIN_BITS;
    localparam int RWB = `NVMSH_ROM_WIN_BITS;

    nvmsh_state_e st_q;
    nvmsh_sidx_t idx_q;
    nvmsh_faddr_t fl_addr_q;
    logic [15:0] fl_wdata_q, hwdata_q, rom_ptr_q, sr_rdata, sr_wdata;
    logic [31:0] flash_bar_q, rom_bar_q, mem_rdata_q, cfg_rdata_q;
    logic [31:0] own_cnt_q;
    logic reload_pend_q, commit_pend_q, valid_sec_q, defaults_q, sig0_ok_q;
    logic rom_ptr_ok_q, mem_ack_q, fw_ack_q, cdone_q, cerr_q, overtime_q;
    logic idle, take_load, take_commit, commit_ok, take_mem, take_fw;
    logic flash_hit, rom_hit, rom_oob, blank_wr, sr_we, sr_re;
    logic [RWB-1:0] rom_off;
    logic [23:0] rom_byte;
    nvmsh_sidx_t sr_addr;

    function automatic logic sig_ok(input logic [15:0] w);
        return !w[`NVMSH_SIG_BIT_HI] && w[`NVMSH_SIG_BIT_LO];
    endfunction

    // ===========================================================
    // request selection
    assign idle = (st_q == ST_IDLE);
    assign take_load = idle && reload_pend_q;
    assign take_commit = idle && !reload_pend_q && commit_pend_q;
    // authentication looked at here only, never during load
    assign commit_ok = FW_OWNS && !(PROTECT_EN && !AUTH_OK);
    assign take_mem = idle && !reload_pend_q && !commit_pend_q &&
        MEM_REQ && !mem_ack_q;
    assign take_fw = idle && !reload_pend_q && !commit_pend_q &&
        !MEM_REQ && FW_SR_REQ && !fw_ack_q;

    // ===========================================================
    // window decode
    assign flash_hit = (MEM_ADDR[31:FWB] == flash_bar_q[31:FWB]);
    assign rom_hit = rom_bar_q[0] && rom_ptr_ok_q &&
        (MEM_ADDR[31:RWB] == rom_bar_q[31:RWB]);
    assign rom_off = MEM_ADDR[RWB-1:0];
    assign rom_oob = ({8'h00, rom_off} >= OPTROM_SIZE);
    assign rom_byte = 24'({rom_ptr_q[11:0], 12'h000}) + 24'(rom_off);
    // blank programming is the only direct write path
    assign blank_wr = flash_hit && BLANK_MODE && !PROTECT_EN;

    // ===========================================================
    // reload and commit requests; a new event beats the clear
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            reload_pend_q <= 1'b1;
        end else if (CLK_EN) begin
            reload_pend_q <= (reload_pend_q && !take_load) ||
                PCI_RST_DONE || WAKE_D3_D0 || SW_RESET;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            commit_pend_q <= 1'b0;
        end else if (CLK_EN) begin
            commit_pend_q <= (commit_pend_q && !take_commit) || FW_COMMIT;
        end
    end

    // ===========================================================
    // main sequencer
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            st_q <= ST_IDLE;
            idx_q <= 13'h0000;
            fl_addr_q <= 22'h000000;
            fl_wdata_q <= 16'h0000;
            hwdata_q <= 16'h0000;
            sig0_ok_q <= 1'b0;
        end else if (CLK_EN) begin
            unique case (st_q)
                ST_IDLE: begin
                    if (take_load) begin
                        fl_addr_q <= 22'h000000;
                        st_q <= ST_SIG0;
                    end else if (take_commit) begin
                        idx_q <= 13'h0001;
                        if (commit_ok) begin
                            st_q <= ST_CRD;
                        end
                    end else if (take_mem && MEM_WE) begin
                        if (blank_wr) begin
                            fl_addr_q <= {MEM_ADDR[FWB-1:2], 1'b0};
                            fl_wdata_q <= MEM_WDATA[15:0];
                            hwdata_q <= MEM_WDATA[31:16];
                            st_q <= ST_HWR0;
                        end
                    end else if (take_mem) begin
                        // requests are served in fixed order: reload, commit, host, firmware
                        if (flash_hit) begin
                            fl_addr_q <= {MEM_ADDR[FWB-1:2], 1'b0};
                            st_q <= ST_HRD0;
                        end else if (rom_hit && !rom_oob) begin
                            // no ownership check: boot reads go straight
                            fl_addr_q <= {rom_byte[22:2], 1'b0};
                            st_q <= ST_HRD0;
                        end
                    end else if (take_fw) begin
                        st_q <= ST_FWACC;
                    end
                end
                ST_SIG0: begin
                    if (FL_ACK) begin
                        sig0_ok_q <= sig_ok(FL_RDATA);
                        fl_addr_q <= `NVMSH_SEC1_WORD;
                        st_q <= ST_SIG1;
                    end
                end
                ST_SIG1: begin
                    if (FL_ACK) begin
                        idx_q <= 13'h0000;
                        if (sig0_ok_q) begin
                            fl_addr_q <= 22'h000000;
                            st_q <= ST_LOAD;
                        end else if (sig_ok(FL_RDATA)) begin
                            fl_addr_q <= `NVMSH_SEC1_WORD;
                            st_q <= ST_LOAD;
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
                ST_LOAD: begin
                    if (FL_ACK) begin
                        idx_q <= idx_q + 13'h0001;
                        fl_addr_q <= fl_addr_q + 22'h000001;
                        if (idx_q == `NVMSH_SEC_WORDS_LAST) begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
                ST_CRD: st_q <= ST_CCAP;
                ST_CCAP: begin
                    fl_addr_q <= {8'h00, !valid_sec_q, idx_q};
                    if (idx_q == 13'h0000) begin
                        fl_wdata_q <= {sr_rdata[15:8], 2'b01,
                            sr_rdata[5:0]};
                    end else begin
                        fl_wdata_q <= sr_rdata;
                    end
                    st_q <= ST_CWR;
                end
                ST_CWR: begin
                    if (FL_ACK) begin
                        // control word goes last so a torn commit stays
                        // invalid
                        if (idx_q == 13'h0000) begin
                            fl_addr_q <= {8'h00, valid_sec_q, 13'h0000};
                            fl_wdata_q <= fl_wdata_q & 16'hffbf;
                            st_q <= ST_CINV;
                        end else begin
                            idx_q <= idx_q + 13'h0001;
                            st_q <= ST_CRD;
                        end
                    end
                end
                ST_CINV: begin
                    if (FL_ACK) begin
                        st_q <= ST_IDLE;
                    end
                end
                ST_HRD0: begin
                    if (FL_ACK) begin
                        fl_addr_q <= fl_addr_q + 22'h000001;
                        st_q <= ST_HRD1;
                    end
                end
                ST_HWR0: begin
                    if (FL_ACK) begin
                        fl_addr_q <= fl_addr_q + 22'h000001;
                        fl_wdata_q <= hwdata_q;
                        st_q <= ST_HWR1;
                    end
                end
                ST_HRD1, ST_HWR1: begin
                    if (FL_ACK) begin
                        st_q <= ST_IDLE;
                    end
                end
                ST_FWACC: st_q <= ST_IDLE;
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ===========================================================
    // section state and option ROM pointer
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            valid_sec_q <= 1'b0;
            defaults_q <= 1'b0;
        end else if (CLK_EN) begin
            if (st_q == ST_SIG1 && FL_ACK) begin
                // with no valid copy, next commit lands in section zero
                valid_sec_q <= !sig0_ok_q;
                defaults_q <= !sig0_ok_q && !sig_ok(FL_RDATA);
            end else if (st_q == ST_CINV && FL_ACK) begin
                valid_sec_q <= !valid_sec_q;
                defaults_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            rom_ptr_q <= 16'h0000;
            rom_ptr_ok_q <= 1'b0;
        end else if (CLK_EN) begin
            if (take_load) begin
                rom_ptr_ok_q <= 1'b0;
            end else if (st_q == ST_LOAD && FL_ACK) begin
                if (idx_q == `NVMSH_ROM_PTR_WORD) begin
                    rom_ptr_q <= FL_RDATA;
                end
                if (idx_q == `NVMSH_SEC_WORDS_LAST) begin
                    rom_ptr_ok_q <= 1'b1;
                end
            end
        end
    end

    // ===========================================================
    // configuration registers
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            flash_bar_q <= `NVMSH_FLASH_BAR_RST;
            rom_bar_q <= `NVMSH_ROM_BAR_RST;
        end else if (CLK_EN && CFG_WE) begin
            if (CFG_ADDR == `NVMSH_CFG_FLASH_BAR) begin
                flash_bar_q <= {CFG_WDATA[31:FWB], {FWB{1'b0}}};
            end
            if (CFG_ADDR == `NVMSH_CFG_ROM_BAR) begin
                rom_bar_q <= {CFG_WDATA[31:RWB], {(RWB-1){1'b0}},
                    CFG_WDATA[0]};
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            cfg_rdata_q <= 32'h0000_0000;
        end else if (CLK_EN) begin
            if (CFG_ADDR == `NVMSH_CFG_FLASH_BAR) begin
                cfg_rdata_q <= flash_bar_q;
            end else if (CFG_ADDR == `NVMSH_CFG_ROM_BAR) begin
                cfg_rdata_q <= rom_bar_q;
            end else begin
                cfg_rdata_q <= 32'h0000_0000;
            end
        end
    end

    // ===========================================================
    // host answers
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            mem_ack_q <= 1'b0;
            mem_rdata_q <= 32'h0000_0000;
        end else if (CLK_EN) begin
            mem_ack_q <= 1'b0;
            if (take_mem && MEM_WE && !blank_wr) begin
                mem_ack_q <= 1'b1;
            end else if (take_mem && !MEM_WE && !flash_hit &&
                (!rom_hit || rom_oob)) begin
                mem_ack_q <= 1'b1;
                mem_rdata_q <= (rom_hit && rom_oob) ?
                    `NVMSH_OOB_PATTERN : 32'h0000_0000;
            end else if (st_q == ST_HRD0 && FL_ACK) begin
                mem_rdata_q[15:0] <= FL_RDATA;
            end else if (st_q == ST_HRD1 && FL_ACK) begin
                mem_rdata_q[31:16] <= FL_RDATA;
                mem_ack_q <= 1'b1;
            end else if (st_q == ST_HWR1 && FL_ACK) begin
                mem_ack_q <= 1'b1;
            end
        end
    end

    // ===========================================================
    // firmware and VPD access, always against the shadow
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            fw_ack_q <= 1'b0;
        end else if (CLK_EN) begin
            fw_ack_q <= (st_q == ST_FWACC);
        end
    end

    assign sr_we = (st_q == ST_LOAD && FL_ACK) ||
        (st_q == ST_FWACC && FW_SR_WE);
    assign sr_re = (st_q == ST_CRD) || (st_q == ST_FWACC && !FW_SR_WE);
    assign sr_addr = (st_q == ST_FWACC) ? FW_SR_ADDR : idx_q;
    assign sr_wdata = (st_q == ST_FWACC) ? FW_SR_WDATA : FL_RDATA;

    nvmsh_sram u_sram (
        .clk(CORE_CLK),
        .en(CLK_EN),
        .addr(sr_addr),
        .we(sr_we),
        .re(sr_re),
        .wdata(sr_wdata),
        .rdata(sr_rdata)
    );

    // ===========================================================
    // commit completion and ownership watch
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            cdone_q <= 1'b0;
            cerr_q <= 1'b0;
        end else if (CLK_EN) begin
            cdone_q <= (take_commit && !commit_ok) ||
                (st_q == ST_CINV && FL_ACK);
            if (take_commit) begin
                cerr_q <= !commit_ok;
            end
        end
    end

    // warns only; releasing the semaphore stays with the holder
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            own_cnt_q <= 32'h0000_0000;
            overtime_q <= 1'b0;
        end else if (CLK_EN) begin
            if (!FW_OWNS) begin
                own_cnt_q <= 32'h0000_0000;
                overtime_q <= 1'b0;
            end else if (own_cnt_q != 32'(OWN_LIMIT_CYC)) begin
                own_cnt_q <= own_cnt_q + 32'h0000_0001;
            end else begin
                overtime_q <= 1'b1;
            end
        end
    end

    // ===========================================================
    // outputs
    assign FL_REQ = (st_q == ST_SIG0) || (st_q == ST_SIG1) ||
        (st_q == ST_LOAD) || (st_q == ST_CWR) || (st_q == ST_CINV) ||
        (st_q == ST_HRD0) || (st_q == ST_HRD1) ||
        (st_q == ST_HWR0) || (st_q == ST_HWR1);
    assign FL_WE = (st_q == ST_CWR) || (st_q == ST_CINV) ||
        (st_q == ST_HWR0) || (st_q == ST_HWR1);
    assign FL_ADDR = fl_addr_q;
    assign FL_WDATA = fl_wdata_q;
    assign MEM_ACK = mem_ack_q;
    assign MEM_RDATA = mem_rdata_q;
    assign FW_SR_ACK = fw_ack_q;
    assign FW_SR_RDATA = sr_rdata;
    assign CFG_RDATA = cfg_rdata_q;
    assign COMMIT_BUSY = (st_q >= ST_CRD) && (st_q <= ST_CINV);
    assign COMMIT_DONE = cdone_q;
    assign COMMIT_ERR = cerr_q;
    assign OWN_OVERTIME = overtime_q;
    assign LOAD_BUSY = reload_pend_q || (st_q == ST_SIG0) ||
        (st_q == ST_SIG1) || (st_q == ST_LOAD);
    assign VALID_SECTION = valid_sec_q;
    assign USING_DEFAULTS = defaults_q;

    // ===========================================================
    // checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST || !CLK_EN);

    sequence s_oob_answer;
        MEM_ACK && (MEM_RDATA == 32'hdeadbeef) && !FL_REQ;
    endsequence

    a_rom_oob_pattern: assert property (
        take_mem && !MEM_WE && !flash_hit && rom_hit && rom_oob
        |=> s_oob_answer) else $error("rom overrun not answered");
    a_prot_no_write: assert property (
        FL_REQ && FL_WE && PROTECT_EN |-> COMMIT_BUSY)
        else $error("direct write while protected");
    a_host_wr_drop: assert property (
        take_mem && MEM_WE && !blank_wr |=> MEM_ACK && !FL_REQ)
        else $error("host write not discarded");
    a_sec0_wins: assert property (
        st_q == ST_SIG1 && FL_ACK && sig0_ok_q
        |=> !VALID_SECTION && st_q == ST_LOAD && FL_ADDR == 22'h0)
        else $error("section zero not preferred");
    a_defaults_used: assert property (
        st_q == ST_SIG1 && FL_ACK && !sig0_ok_q && !sig_ok(FL_RDATA)
        |=> USING_DEFAULTS && idle) else $error("defaults not taken");
    a_commit_other: assert property (
        st_q == ST_CWR |-> FL_ADDR[13] == !valid_sec_q)
        else $error("commit hits valid section");
    a_mark_valid: assert property (
        st_q == ST_CWR && idx_q == 13'h0 |-> FL_WDATA[7:6] == 2'b01)
        else $error("control word not marked");
    a_load_read_only: assert property (
        (st_q == ST_SIG0 || st_q == ST_SIG1 || st_q == ST_LOAD) && FL_REQ
        |-> !FL_WE) else $error("write during load");
    a_commit_own: assert property (
        take_commit && !FW_OWNS |=> !COMMIT_BUSY && COMMIT_DONE
        && COMMIT_ERR) else $error("commit without ownership");
    a_own_limit: assert property (
        FW_OWNS && own_cnt_q == 32'(OWN_LIMIT_CYC) |=> OWN_OVERTIME)
        else $error("overtime not flagged");
    a_reload_trig: assert property (
        idle && SW_RESET |=> reload_pend_q || st_q == ST_SIG0)
        else $error("reload not requested");
endmodule

// *** src/nvmsh_regs.svh ***
`ifndef NVMSH_REGS_SVH
`define NVMSH_REGS_SVH

// ===========================================================
// configuration space offsets
`define NVMSH_CFG_FLASH_BAR 8'h10
`define NVMSH_CFG_ROM_BAR 8'h30

// ===========================================================
// flash layout
`define NVMSH_SEC1_WORD 22'h002000
`define NVMSH_SEC_WORDS_LAST 13'h1fff
`define NVMSH_SIG_BIT_HI 7
`define NVMSH_SIG_BIT_LO 6
`define NVMSH_ROM_PTR_WORD 13'h0005
`define NVMSH_ROM_PTR_SHIFT 12
`define NVMSH_FLASH_WIN_BITS 23
`define NVMSH_ROM_WIN_BITS 16
`define NVMSH_OOB_PATTERN 32'hdeadbeef

// ===========================================================
// reset values and timing
`define NVMSH_FLASH_BAR_RST 32'h0000_0000
`define NVMSH_ROM_BAR_RST 32'h0000_0000
`define NVMSH_CLK_NS 100
`define NVMSH_OWN_MAX_MS 500
`define NVMSH_OWN_MAX_CYC (`NVMSH_OWN_MAX_MS * 1000000 / `NVMSH_CLK_NS)
`endif

// *** src/nvmsh_pkg.sv ***
package nvmsh_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_SIG0 = 4'b0001,
        ST_SIG1 = 4'b0010,
        ST_LOAD = 4'b0011,
        ST_CRD = 4'b0100,
        ST_CCAP = 4'b0101,
        ST_CWR = 4'b0110,
        ST_CINV = 4'b0111,
        ST_HRD0 = 4'b1000,
        ST_HRD1 = 4'b1001,
        ST_HWR0 = 4'b1010,
        ST_HWR1 = 4'b1011,
        ST_FWACC = 4'b1100
    } nvmsh_state_e;
    typedef logic [12:0] nvmsh_sidx_t;
    typedef logic [21:0] nvmsh_faddr_t;
endpackage

// *** src/nvmsh_sram.sv ***
`timescale 1ns/10ps
// ===========================================================
// shadow RAM, 8192 x 16, registered read
module nvmsh_sram
    import nvmsh_pkg::*;
(
    // clocking
    input wire logic clk,
    input wire logic en,
    // access
    input wire nvmsh_sidx_t addr,
    input wire logic we,
    input wire logic re,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata
);
    logic [15:0] mem_q [0:8191];

    always_ff @(posedge clk) begin
        if (en && we) begin
            mem_q[addr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (en && re) begin
            rdata <= mem_q[addr];
        end
    end
endmodule

// *** tb/nvmsh_flash_model.sv ***
`timescale 1ns/10ps
// ===========================================================
// flash word device, answers after dly idle cycles
module nvmsh_flash_model (
    // control
    input wire logic clk,
    input wire logic [3:0] dly,
    // word port
    input wire logic req,
    input wire logic we,
    input wire logic [21:0] addr,
    input wire logic [15:0] wdata,
    output logic ack,
    output logic [15:0] rdata
);
    logic [15:0] mem [int];
    logic [3:0] cnt = 4'h0;
    initial {ack, rdata} = '0;
    always @(posedge clk) begin
        if (req && !ack && cnt >= dly) begin
            ack <= 1'b1;
            cnt <= 4'h0;
            if (we) mem[addr] = wdata;
            rdata <= mem.exists(addr) ? mem[addr] : addr[15:0] ^ 16'h5a5a;
        end else begin
            // data toggles off-ack so a late sample cannot pass by luck
            ack <= 1'b0;
            rdata <= ~rdata;
            cnt <= req ? cnt + 4'h1 : 4'h0;
        end
    end
endmodule

// *** tb/nvmsh_top_tb.sv ***
`timescale 1ns/10ps
// ===========================================================
// bench for the shadow flash window
module nvmsh_top_tb import nvmsh_pkg::*;;
    logic CORE_CLK = 1'b0, SYS_RST, CLK_EN, PCI_RST_DONE, WAKE_D3_D0;
    logic SW_RESET, CFG_WE, MEM_REQ, MEM_WE, FW_SR_REQ, FW_SR_WE, FW_COMMIT;
    logic FW_OWNS, AUTH_OK, PROTECT_EN, BLANK_MODE, MEM_ACK, FW_SR_ACK;
    logic COMMIT_BUSY, COMMIT_DONE, COMMIT_ERR, OWN_OVERTIME, LOAD_BUSY;
    logic VALID_SECTION, USING_DEFAULTS, FL_REQ, FL_WE, FL_ACK, seen;
    logic [7:0] CFG_ADDR;
    logic [31:0] CFG_WDATA, CFG_RDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA, rd;
    logic [15:0] FW_SR_WDATA, FW_SR_RDATA, FL_WDATA, FL_RDATA;
    logic [23:0] OPTROM_SIZE = 24'h000100;
    logic [3:0] dly;
    nvmsh_sidx_t FW_SR_ADDR;
    nvmsh_faddr_t FL_ADDR;
    int n_mismatch = 0, n_checks = 0;
    nvmsh_top #(.OWN_LIMIT_CYC(20)) i_nvmsh_top (.*);
    nvmsh_flash_model i_nvmsh_flash_model (.clk(CORE_CLK), .dly(dly),
        .req(FL_REQ), .we(FL_WE), .addr(FL_ADDR), .wdata(FL_WDATA),
        .ack(FL_ACK), .rdata(FL_RDATA));
    always #50 CORE_CLK = ~CORE_CLK;
    // done is a one-cycle pulse, so it is caught here rather than polled
    always @(posedge CORE_CLK) seen <= !FW_COMMIT && (seen || COMMIT_DONE);
    function automatic logic [15:0] pat(input logic [21:0] a);
        return a[15:0] ^ 16'h5a5a;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic await(input int k, input int lim);
        for (int i = 0; i <= lim; i++) begin
            @(negedge CORE_CLK);
            if (k == 0 && LOAD_BUSY === 1'b0 || k == 1 && MEM_ACK === 1'b1
                || k == 2 && FW_SR_ACK === 1'b1 || k == 3 && seen === 1'b1)
                return;
        end
        n_mismatch++;
        end_of_test();
    endtask
    task automatic mem_rw(input logic w, input logic [31:0] a, d);
        @(negedge CORE_CLK);
        {MEM_REQ, MEM_WE, MEM_ADDR, MEM_WDATA} = {1'b1, w, a, d};
        await(1, 200);
        rd = MEM_RDATA;
        @(negedge CORE_CLK);
        MEM_REQ = 1'b0;
    endtask
    task automatic fw_rw(input logic w, input nvmsh_sidx_t a,
        input logic [15:0] d);
        @(negedge CORE_CLK);
        {FW_SR_REQ, FW_SR_WE, FW_SR_ADDR, FW_SR_WDATA} = {1'b1, w, a, d};
        await(2, 200);
        rd = {16'h0000, FW_SR_RDATA};
        @(negedge CORE_CLK);
        FW_SR_REQ = 1'b0;
    endtask
    task automatic cfg(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(negedge CORE_CLK);
        {CFG_WE, CFG_ADDR, CFG_WDATA} = {w, a, d};
        @(negedge CORE_CLK);
        CFG_WE = 1'b0;
        rd = CFG_RDATA;
    endtask
    task automatic pulse(input int k);
        @(negedge CORE_CLK);
        {FW_COMMIT, PCI_RST_DONE, WAKE_D3_D0, SW_RESET} = 4'h1 << k;
        @(negedge CORE_CLK);
        {FW_COMMIT, PCI_RST_DONE, WAKE_D3_D0, SW_RESET} = 4'h0;
    endtask
    initial begin
        {SYS_RST, CLK_EN, PCI_RST_DONE, WAKE_D3_D0, SW_RESET, CFG_WE} = 6'h30;
        {MEM_REQ, MEM_WE, FW_SR_REQ, FW_SR_WE, FW_COMMIT, FW_OWNS} = '0;
        {AUTH_OK, PROTECT_EN, BLANK_MODE, dly, rd} = '0;
        {CFG_ADDR, CFG_WDATA, MEM_ADDR, MEM_WDATA} = '0;
        {FW_SR_ADDR, FW_SR_WDATA} = '0;
        i_nvmsh_flash_model.mem[0] = 16'h0040;
        i_nvmsh_flash_model.mem[22'h2000] = 16'h0041;
        i_nvmsh_flash_model.mem[5] = 16'h0002;
        repeat (6) @(negedge CORE_CLK);
        SYS_RST = 1'b0;
        await(0, 40000);
        chk({VALID_SECTION, USING_DEFAULTS}, 2'h0);
        fw_rw(1'b0, 13'h0005, 16'h0000);
        chk(rd, 32'h2);
        cfg(1'b1, 8'h10, 32'h8000_0000);
        cfg(1'b1, 8'h30, 32'h9000_0001);
        cfg(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h8000_0000);
        cfg(1'b0, 8'h30, 32'h0);
        chk(rd, 32'h9000_0001);
        dly = 4'h3;
        mem_rw(1'b0, 32'h8000_0010, 32'h0);
        chk(rd, {pat(22'h9), pat(22'h8)});
        mem_rw(1'b0, 32'h9000_0004, 32'h0);
        chk(rd, {pat(22'h1003), pat(22'h1002)});
        mem_rw(1'b0, 32'h9000_0100, 32'h0);
        chk(rd, 32'hdeadbeef);
        dly = 4'h0;
        {PROTECT_EN, BLANK_MODE} = 2'h3;
        mem_rw(1'b1, 32'h8000_0020, 32'h1111_2222);
        mem_rw(1'b0, 32'h8000_0020, 32'h0);
        chk(rd, {pat(22'h11), pat(22'h10)});
        PROTECT_EN = 1'b0;
        mem_rw(1'b1, 32'h8000_0020, 32'h3333_4444);
        mem_rw(1'b0, 32'h8000_0020, 32'h0);
        chk(rd, 32'h3333_4444);
        fw_rw(1'b1, 13'h0003, 16'h1234);
        pulse(3);
        await(3, 50);
        chk(COMMIT_ERR, 32'h1);
        {FW_OWNS, PROTECT_EN} = 2'h3;
        pulse(3);
        await(3, 50);
        chk(COMMIT_ERR, 32'h1);
        AUTH_OK = 1'b1;
        pulse(3);
        await(3, 60000);
        chk({COMMIT_ERR, VALID_SECTION, OWN_OVERTIME}, 3'h3);
        chk(i_nvmsh_flash_model.mem[22'h2003], 16'h1234);
        chk(i_nvmsh_flash_model.mem[22'h2000][7:6], 2'h1);
        chk(i_nvmsh_flash_model.mem[0][6], 1'h0);
        FW_OWNS = 1'b0;
        fw_rw(1'b1, 13'h0003, 16'h5555);
        pulse(0);
        await(0, 40000);
        chk({VALID_SECTION, USING_DEFAULTS}, 2'h2);
        fw_rw(1'b0, 13'h0003, 16'h0000);
        chk(rd, 32'h1234);
        i_nvmsh_flash_model.mem[22'h2000] = 16'h0000;
        pulse(1);
        await(0, 40000);
        chk(USING_DEFAULTS, 32'h1);
        i_nvmsh_flash_model.mem[0] = 16'h0040;
        pulse(2);
        await(0, 40000);
        chk({VALID_SECTION, USING_DEFAULTS}, 2'h0);
        end_of_test();
    end
endmodule
